/* File: rtl/utx_pkg.sv */
// Shared constants, types and functions for the transmit cell port
// Behaviour
// - Data bus is 16 bits, or 8 in byte mode
// - MSB is bit 15, or bit 7 in byte mode
// - Device ignores data between cells until start-of-cell
// - Master drives odd or even parity per word
// - Device captures parity on link clock rise
// - Master raises start-of-cell with first word only
// - Start word followed by 26 words or 52 bytes
// - After full cell, wait for start plus enable
// - Device samples data and controls on clock rise
// - Enable low exactly while data is valid
// - Device gives tri-stateable active-high cell-available flag
// - Master drives five-bit address to poll and select
`default_nettype none
package utx_pkg;
    localparam int          UTX_DATA_W       = 16;
    localparam int          UTX_ADDR_W       = 5;
    localparam int          UTX_MSB_WORD     = 15;
    localparam int          UTX_MSB_BYTE     = 7;
    localparam logic [5:0]  UTX_LAST_WORD    = 6'h1A;
    localparam logic [5:0]  UTX_LAST_BYTE    = 6'h34;
    localparam int          UTX_FIFO_DEPTH   = 8;
    localparam int          UTX_CLAV_ROOM    = 4;
    localparam int          UTX_MCLK_NS      = 50;
    localparam int          UTX_LINK_NS      = 400;
    localparam int          UTX_LINK_HALF    = UTX_LINK_NS / (2 * UTX_MCLK_NS);
    localparam logic [1:0]  UTX_POLL_FALLS   = 2'h2;

    typedef enum logic [1:0] {
        UTX_PHY_IDLE,
        UTX_PHY_CELL
    } utx_phy_state_type;

    typedef enum logic [1:0] {
        UTX_ATM_IDLE,
        UTX_ATM_POLL,
        UTX_ATM_SEND
    } utx_atm_state_type;

    // Keeps only the active lanes of the data bus
    function automatic logic [UTX_DATA_W-1:0] utxMask(input logic [UTX_DATA_W-1:0] d,
                                                     input logic byteMode);
        utxMask = byteMode ? {8'h00, d[UTX_MSB_BYTE:0]} : d;
    endfunction

    // Parity bit over the active lanes
    function automatic logic utxParity(input logic [UTX_DATA_W-1:0] d,
                                       input logic byteMode,
                                       input logic odd);
        logic [UTX_DATA_W-1:0] m;
        m = utxMask(d, byteMode);
        utxParity = odd ? ~(^m) : (^m);
    endfunction

    function automatic logic [5:0] utxLast(input logic byteMode);
        utxLast = byteMode ? UTX_LAST_BYTE : UTX_LAST_WORD;
    endfunction
endpackage
`default_nettype wire

/* File: rtl/utx_link_if.sv */
// Link wires between the cell master and the PHY end
`timescale 1ns/100ps
`default_nettype none
interface utx_link_if;
    import utx_pkg::*;
    logic                  txClk;
    logic [UTX_DATA_W-1:0] txData;
    logic                  txPar;
    logic                  txSoc;
    logic                  txEnb_n;
    logic [UTX_ADDR_W-1:0] txAddr;
    logic                  txClavOut;
    logic                  txClavOe;
    logic                  txClav;

    // Shared flag line: reads low when no PHY drives it
    assign txClav = txClavOe ? txClavOut : 1'b0;

    modport phy (
        input  txClk,
        input  txData,
        input  txPar,
        input  txSoc,
        input  txEnb_n,
        input  txAddr,
        output txClavOut,
        output txClavOe
    );

    modport atm (
        output txClk,
        output txData,
        output txPar,
        output txSoc,
        output txEnb_n,
        output txAddr,
        input  txClav
    );
endinterface
`default_nettype wire

/* File: rtl/utx_phy_end.sv */
// PHY end of the transmit cell port with its word FIFO
`timescale 1ns/100ps
`default_nettype none
module utx_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData,
    output logic      [$clog2(DEPTH+1)-1:0] fill
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

    if (DEPTH < 2) begin : g_check
        $error("utx_fifo needs a depth of at least two");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wrPtr_reg;
    logic [PW-1:0]    wrPtr_next;
    logic [PW-1:0]    rdPtr_reg;
    logic [PW-1:0]    rdPtr_next;
    logic [CW-1:0]    count_reg;
    logic [CW-1:0]    count_next;
    logic             push;
    logic             pop;

    assign inReady  = (count_reg != CW'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData  = mem_reg[rdPtr_reg];
    assign fill     = count_reg;
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        wrPtr_next = wrPtr_reg;
        rdPtr_next = rdPtr_reg;
        count_next = count_reg;
        if (push) begin
            wrPtr_next = (wrPtr_reg == PTR_LAST) ? '0 : wrPtr_reg + 1'b1;
        end
        if (pop) begin
            rdPtr_next = (rdPtr_reg == PTR_LAST) ? '0 : rdPtr_reg + 1'b1;
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
        end
    end

    // Storage needs no reset; only written words are ever read
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_reg[wrPtr_reg] <= inData;
        end
    end
endmodule

module utx_phy_end
    import utx_pkg::*;
#(
    parameter int DEPTH = UTX_FIFO_DEPTH,
    parameter int ROOM  = UTX_CLAV_ROOM
) (
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    utx_link_if.phy                    link,
    input  wire logic                  byteMode,
    input  wire logic                  parityOdd,
    input  wire logic [UTX_ADDR_W-1:0] ownAddr,
    output logic      [UTX_DATA_W-1:0] cellData,
    output logic                       cellSoc,
    output logic                       cellValid,
    input  wire logic                  cellReady,
    output logic                       parityErr,
    output logic                       overflow
);
    localparam int SW = UTX_DATA_W + UTX_ADDR_W + 4;
    localparam int FW = UTX_DATA_W + 1;
    localparam int CW = $clog2(DEPTH + 1);

    if (ROOM < 1 || ROOM > DEPTH) begin : g_check
        $error("utx_phy_end needs 1 <= ROOM <= DEPTH");
    end

    // Two-stage synchroniser for every link input
    logic [SW-1:0] syncA_reg;
    logic [SW-1:0] syncB_reg;
    logic          clkPrev_reg;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            syncA_reg   <= '0;
            syncB_reg   <= '0;
            clkPrev_reg <= 1'b0;
        end else begin
            syncA_reg   <= {link.txClk, link.txSoc, link.txEnb_n, link.txPar,
                            link.txAddr, link.txData};
            syncB_reg   <= syncA_reg;
            clkPrev_reg <= syncB_reg[SW-1];
        end
    end

    logic                  sClk;
    logic                  sSoc;
    logic                  sEnb_n;
    logic                  sPar;
    logic [UTX_ADDR_W-1:0] sAddr;
    logic [UTX_DATA_W-1:0] sData;
    logic                  linkRise;

    assign {sClk, sSoc, sEnb_n, sPar, sAddr, sData} = syncB_reg;
    assign linkRise = sClk && !clkPrev_reg;

    // Cell framing
    utx_phy_state_type     state_reg;
    utx_phy_state_type     state_next;
    logic [5:0]            idx_reg;
    logic [5:0]            idx_next;
    logic                  push_reg;
    logic                  push_next;
    logic [FW-1:0]         pushData_reg;
    logic [FW-1:0]         pushData_next;
    logic                  parityErr_reg;
    logic                  parityErr_next;
    logic                  overflow_reg;
    logic                  overflow_next;
    logic                  clav_reg;
    logic                  clav_next;
    logic                  clavOe_reg;
    logic                  clavOe_next;
    logic                  fifoReady;
    logic [CW-1:0]         fifoFill;
    logic                  take;

    always_comb begin
        state_next     = state_reg;
        idx_next       = idx_reg;
        push_next      = 1'b0;
        pushData_next  = pushData_reg;
        parityErr_next = 1'b0;
        overflow_next  = push_reg && !fifoReady;
        take           = 1'b0;
        if (linkRise && !sEnb_n) begin
            if (sSoc) begin
                take       = 1'b1;
                idx_next   = '0;
                state_next = UTX_PHY_CELL;
            end else if (state_reg == UTX_PHY_CELL) begin
                take     = 1'b1;
                idx_next = idx_reg + 1'b1;
                if (idx_next == utxLast(byteMode)) begin
                    state_next = UTX_PHY_IDLE;
                end
            end
        end
        if (take) begin
            push_next      = 1'b1;
            pushData_next  = {sSoc, utxMask(sData, byteMode)};
            parityErr_next = (sPar != utxParity(sData, byteMode, parityOdd));
        end
        // Flag room only while at least ROOM FIFO slots are free
        clav_next   = (fifoFill <= CW'(DEPTH - ROOM));
        clavOe_next = (sAddr == ownAddr);
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg     <= UTX_PHY_IDLE;
            idx_reg       <= '0;
            push_reg      <= 1'b0;
            pushData_reg  <= '0;
            parityErr_reg <= 1'b0;
            overflow_reg  <= 1'b0;
            clav_reg      <= 1'b0;
            clavOe_reg    <= 1'b0;
        end else begin
            state_reg     <= state_next;
            idx_reg       <= idx_next;
            push_reg      <= push_next;
            pushData_reg  <= pushData_next;
            parityErr_reg <= parityErr_next;
            overflow_reg  <= overflow_next;
            clav_reg      <= clav_next;
            clavOe_reg    <= clavOe_next;
        end
    end

    logic [FW-1:0] fifoOut;

    utx_fifo #(
        .WIDTH (FW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .inValid  (push_reg),
        .inReady  (fifoReady),
        .inData   (pushData_reg),
        .outValid (cellValid),
        .outReady (cellReady),
        .outData  (fifoOut),
        .fill     (fifoFill)
    );

    assign {cellSoc, cellData} = fifoOut;
    assign parityErr           = parityErr_reg;
    assign overflow            = overflow_reg;
    assign link.txClavOut      = clav_reg;
    assign link.txClavOe       = clavOe_reg;
endmodule
`default_nettype wire

/* File: rtl/utx_atm_end.sv */
// Cell master end: makes the link clock, polls and sends cells
`timescale 1ns/100ps
`default_nettype none
module utx_atm_end
    import utx_pkg::*;
#(
    parameter int HALF = UTX_LINK_HALF
) (
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    utx_link_if.atm                    link,
    input  wire logic                  byteMode,
    input  wire logic                  parityOdd,
    input  wire logic                  sendReq,
    input  wire logic [UTX_ADDR_W-1:0] sendAddr,
    input  wire logic [UTX_DATA_W-1:0] wordData,
    output logic                       wordTake,
    output logic                       sendDone,
    output logic                       busy
);
    if (HALF < 2 || HALF > 255) begin : g_check
        $error("utx_atm_end needs 2 <= HALF <= 255");
    end

    localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

    // Link clock divider; data and controls change on its falling edge, the address when sendReq is taken
    logic [7:0] div_reg;
    logic [7:0] div_next;
    logic       clk_reg;
    logic       clk_next;
    logic       fall;

    always_comb begin
        div_next = (div_reg == HALF_LAST) ? 8'h00 : div_reg + 8'h01;
        clk_next = (div_reg == HALF_LAST) ? !clk_reg : clk_reg;
        fall     = (div_reg == HALF_LAST) && clk_reg;
    end

    // Cell-available flag passes two flip-flops
    logic clavA_reg;
    logic clavB_reg;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            div_reg   <= 8'h00;
            clk_reg   <= 1'b0;
            clavA_reg <= 1'b0;
            clavB_reg <= 1'b0;
        end else begin
            div_reg   <= div_next;
            clk_reg   <= clk_next;
            clavA_reg <= link.txClav;
            clavB_reg <= clavA_reg;
        end
    end

    utx_atm_state_type     state_reg;
    utx_atm_state_type     state_next;
    logic [5:0]            idx_reg;
    logic [5:0]            idx_next;
    logic [1:0]            wait_reg;
    logic [1:0]            wait_next;
    logic [UTX_ADDR_W-1:0] addr_reg;
    logic [UTX_ADDR_W-1:0] addr_next;
    logic [UTX_DATA_W-1:0] data_reg;
    logic [UTX_DATA_W-1:0] data_next;
    logic                  par_reg;
    logic                  par_next;
    logic                  soc_reg;
    logic                  soc_next;
    logic                  enb_n_reg;
    logic                  enb_n_next;
    logic                  take_reg;
    logic                  take_next;
    logic                  done_reg;
    logic                  done_next;
    logic                  load;
    logic                  busy_reg;
    logic                  busy_next;

    always_comb begin
        state_next = state_reg;
        idx_next   = idx_reg;
        wait_next  = wait_reg;
        addr_next  = addr_reg;
        data_next  = data_reg;
        par_next   = par_reg;
        soc_next   = soc_reg;
        enb_n_next = enb_n_reg;
        take_next  = 1'b0;
        done_next  = 1'b0;
        load       = 1'b0;
        case (state_reg)
            UTX_ATM_IDLE: begin
                if (sendReq) begin
                    addr_next  = sendAddr;
                    wait_next  = '0;
                    state_next = UTX_ATM_POLL;
                end
            end
            UTX_ATM_POLL: begin
                if (fall) begin
                    if (wait_reg != UTX_POLL_FALLS) begin
                        wait_next = wait_reg + 2'h1;
                    end else if (clavB_reg) begin
                        load       = 1'b1;
                        soc_next   = 1'b1;
                        idx_next   = '0;
                        state_next = UTX_ATM_SEND;
                    end
                end
            end
            UTX_ATM_SEND: begin
                if (fall) begin
                    soc_next = 1'b0;
                    if (idx_reg == utxLast(byteMode)) begin
                        enb_n_next = 1'b1;
                        done_next  = 1'b1;
                        state_next = UTX_ATM_IDLE;
                    end else begin
                        load     = 1'b1;
                        idx_next = idx_reg + 6'h01;
                    end
                end
            end
            default: begin
                state_next = UTX_ATM_IDLE;
            end
        endcase
        if (load) begin
            enb_n_next = 1'b0;
            take_next  = 1'b1;
            data_next  = utxMask(wordData, byteMode);
            par_next   = utxParity(wordData, byteMode, parityOdd);
        end
        // Registered so the status output comes straight from a flip-flop
        busy_next = (state_next != UTX_ATM_IDLE);
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= UTX_ATM_IDLE;
            idx_reg   <= '0;
            wait_reg  <= '0;
            addr_reg  <= '0;
            data_reg  <= '0;
            par_reg   <= 1'b0;
            soc_reg   <= 1'b0;
            enb_n_reg <= 1'b1;
            take_reg  <= 1'b0;
            done_reg  <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            idx_reg   <= idx_next;
            wait_reg  <= wait_next;
            addr_reg  <= addr_next;
            data_reg  <= data_next;
            par_reg   <= par_next;
            soc_reg   <= soc_next;
            enb_n_reg <= enb_n_next;
            take_reg  <= take_next;
            done_reg  <= done_next;
            busy_reg  <= busy_next;
        end
    end

    assign link.txClk   = clk_reg;
    assign link.txData  = data_reg;
    assign link.txPar   = par_reg;
    assign link.txSoc   = soc_reg;
    assign link.txEnb_n = enb_n_reg;
    assign link.txAddr  = addr_reg;
    assign wordTake     = take_reg;
    assign sendDone     = done_reg;
    assign busy         = busy_reg;
endmodule
`default_nettype wire

/* File: tb/utx_monitor.sv */
// Link checker for the transmit cell port
`timescale 1ns/100ps
`default_nettype none
module utx_monitor
    import utx_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    input  wire logic                  txClk,
    input  wire logic [UTX_DATA_W-1:0] txData,
    input  wire logic                  txPar,
    input  wire logic                  txSoc,
    input  wire logic                  txEnb_n,
    input  wire logic [UTX_ADDR_W-1:0] txAddr,
    input  wire logic                  txClavOe,
    input  wire logic                  byteMode,
    input  wire logic                  parityOdd,
    input  wire logic [UTX_ADDR_W-1:0] ownAddr
);
    logic                  clkPrev_reg;
    logic                  clkPrev_next;
    logic [5:0]            cnt_reg;
    logic [5:0]            cnt_next;
    logic                  rise;
    logic                  match;
    logic [5:0]            last;
    logic [UTX_DATA_W-1:0] mData;

    // Word index within the cell, counted at link clock rises
    always_comb begin
        rise = txClk & ~clkPrev_reg;
        match = txAddr == ownAddr;
        last = byteMode ? 6'h34 : 6'h1A;
        mData = byteMode ? {8'h00, txData[7:0]} : txData;
        clkPrev_next = txClk;
        cnt_next = cnt_reg;
        if (rise && !txEnb_n) begin
            cnt_next = txSoc ? 6'h00 : cnt_reg + 6'h01;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            clkPrev_reg <= 1'b0;
            cnt_reg <= 6'h00;
        end else begin
            clkPrev_reg <= clkPrev_next;
            cnt_reg <= cnt_next;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence socHeld;
        txSoc [*8] ##1 !txSoc;
    endsequence

    par_match_a: assert property (!txEnb_n |-> txPar == (^mData ^ parityOdd))
        else $error("link parity does not match data");
    byte_upper_a: assert property (byteMode && !txEnb_n |-> txData[15:8] == 8'h00)
        else $error("upper lanes driven in byte mode");
    data_stable_a: assert property ($changed(txData) || $changed(txEnb_n) |-> !txClk)
        else $error("link data changed while link clock high");
    soc_enb_a: assert property (txSoc |-> !txEnb_n)
        else $error("start of cell without enable");
    enb_start_a: assert property ($fell(txEnb_n) |-> txSoc)
        else $error("cell began without start of cell");
    soc_width_a: assert property ($rose(txSoc) |-> socHeld)
        else $error("start of cell not one link period");
    cell_len_a: assert property (rise && !txEnb_n && !txSoc |-> cnt_reg < last)
        else $error("cell longer than allowed");
    cell_end_a: assert property ($rose(txEnb_n) |-> cnt_reg == last)
        else $error("cell ended early");
    clav_on_a: assert property (match [*6] |-> txClavOe)
        else $error("flag not driven for own address");
    clav_off_a: assert property (!match [*6] |-> !txClavOe)
        else $error("flag driven for foreign address");
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench: cells from master end across the link into the PHY FIFO
`timescale 1ns/100ps
`default_nettype none
module tb;
    import utx_pkg::*;
    logic                  mclk = 1'b0;
    logic                  reset_n = 1'b0;
    logic                  byteMode = 1'b0;
    logic                  atmOdd = 1'b0;
    logic                  phyOdd = 1'b0;
    logic [UTX_ADDR_W-1:0] ownAddr = 5'h0B;
    logic                  sendReq = 1'b0;
    logic [UTX_ADDR_W-1:0] sendAddr = 5'h00;
    logic [UTX_DATA_W-1:0] wordData = 16'h0000;
    logic                  cellReady = 1'b0;
    logic                  drainOn = 1'b1;
    logic [UTX_DATA_W-1:0] cellData;
    logic                  cellSoc;
    logic                  cellValid;
    logic                  parityErr;
    logic                  overflow;
    logic                  wordTake;
    logic                  sendDone;
    logic                  busy;
    logic [UTX_DATA_W-1:0] sendQ[$];
    logic [16:0]           gotQ[$];
    int                    err_count = 0;
    int                    checks_done = 0;
    int                    parCnt = 0;
    int                    ovfCnt = 0;
    int                    idx = 0;

    always #(UTX_MCLK_NS / 2) mclk = ~mclk;

    utx_link_if utx_link_if_inst ();
    utx_atm_end utx_atm_end_inst (.mclk(mclk), .reset_n(reset_n), .link(utx_link_if_inst.atm),
        .byteMode(byteMode), .parityOdd(atmOdd), .sendReq(sendReq), .sendAddr(sendAddr),
        .wordData(wordData), .wordTake(wordTake), .sendDone(sendDone), .busy(busy));
    utx_phy_end utx_phy_end_inst (.mclk(mclk), .reset_n(reset_n), .link(utx_link_if_inst.phy),
        .byteMode(byteMode), .parityOdd(phyOdd), .ownAddr(ownAddr), .cellData(cellData),
        .cellSoc(cellSoc), .cellValid(cellValid), .cellReady(cellReady),
        .parityErr(parityErr), .overflow(overflow));
    utx_monitor utx_monitor_inst (.mclk(mclk), .reset_n(reset_n),
        .txClk(utx_link_if_inst.txClk), .txData(utx_link_if_inst.txData),
        .txPar(utx_link_if_inst.txPar), .txSoc(utx_link_if_inst.txSoc),
        .txEnb_n(utx_link_if_inst.txEnb_n), .txAddr(utx_link_if_inst.txAddr),
        .txClavOe(utx_link_if_inst.txClavOe), .byteMode(byteMode), .parityOdd(atmOdd),
        .ownAddr(ownAddr));

    function automatic logic [UTX_DATA_W-1:0] expWord(input logic [UTX_DATA_W-1:0] d);
        expWord = byteMode ? {8'h00, d[7:0]} : d;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // User side of the FIFO and the PHY's pulses
    always @(posedge mclk) begin
        if (cellValid === 1'b1 && cellReady === 1'b1) begin
            gotQ.push_back({cellSoc, cellData});
        end
        if (parityErr === 1'b1) begin
            parCnt++;
        end
        if (overflow === 1'b1) begin
            ovfCnt++;
        end
    end

    // Next word is presented once the master has taken the current one
    always @(negedge mclk) begin
        cellReady = drainOn && ($urandom % 4 != 0);
        if (wordTake === 1'b1 && idx + 1 < sendQ.size()) begin
            idx = idx + 1;
            wordData = sendQ[idx];
        end
    end

    task automatic wait_done();
        int k;
        for (k = 0; k < 3000 && sendDone !== 1'b1; k++) begin
            @(negedge mclk);
        end
        check(32'(k < 3000), 32'h1);
        repeat (60) @(negedge mclk);
    endtask

    task automatic send_cell(input logic [UTX_ADDR_W-1:0] addr, input logic waitDone);
        int n;
        n = byteMode ? 53 : 27;
        sendQ.delete();
        gotQ.delete();
        parCnt = 0;
        ovfCnt = 0;
        idx = 0;
        for (int i = 0; i < n; i++) begin
            sendQ.push_back(i == 1 ? 16'hFFFF : (i == 2 ? 16'h0000 : 16'($urandom)));
        end
        @(negedge mclk);
        wordData = sendQ[0];
        sendAddr = addr;
        sendReq = 1'b1;
        @(negedge mclk);
        sendReq = 1'b0;
        if (waitDone) begin
            wait_done();
        end
    endtask

    task automatic compare_cell(input int n);
        check(32'(gotQ.size()), 32'(n));
        for (int i = 0; i < n && i < gotQ.size(); i++) begin
            check({15'h0, gotQ[i]}, {15'h0, i == 0, expWord(sendQ[i])});
        end
    endtask

    initial begin
        void'($urandom(32'h35FA));
        repeat (8) @(negedge mclk);
        reset_n = 1'b1;
        repeat (2) @(negedge mclk);
        // Both bus widths with both parity senses
        for (int m = 0; m < 4; m++) begin
            byteMode = m[1];
            atmOdd = m[0];
            phyOdd = m[0];
            send_cell(ownAddr, 1'b1);
            compare_cell(byteMode ? 53 : 27);
            check(32'(parCnt), 32'h0);
            check(32'(ovfCnt), 32'h0);
        end
        // Parity sense disagrees: every word flagged yet kept
        byteMode = 1'b0;
        atmOdd = 1'b1;
        phyOdd = 1'b0;
        send_cell(ownAddr, 1'b1);
        check(32'(parCnt), 32'h1B);
        compare_cell(27);
        phyOdd = 1'b1;
        // Foreign address: flag undriven, master waits
        ownAddr = 5'h14;
        send_cell(5'h15, 1'b0);
        repeat (80) @(negedge mclk);
        check({31'h0, utx_link_if_inst.txClavOe}, 32'h0);
        check({27'h0, utx_link_if_inst.txAddr}, 32'h15);
        check({31'h0, busy}, 32'h1);
        check(32'(gotQ.size()), 32'h0);
        ownAddr = 5'h15;
        wait_done();
        compare_cell(27);
        // Stalled user side: FIFO fills, drops the rest, flag falls
        drainOn = 1'b0;
        send_cell(ownAddr, 1'b1);
        check(32'(ovfCnt), 32'(27 - UTX_FIFO_DEPTH));
        check({31'h0, utx_link_if_inst.txClav}, 32'h0);
        drainOn = 1'b1;
        repeat (60) @(negedge mclk);
        compare_cell(UTX_FIFO_DEPTH);
        check({31'h0, utx_link_if_inst.txClav}, 32'h1);
        give_verdict();
    end

    // Roughly 20000 clock cycles, well above the expected run
    initial begin
        #(1_000_000);
        err_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
